// *** design/flash_fault_defs.vh ***
// constants for the flash fault supervisor: register map, field positions,
// startup values and timing counts.
// assumes a 100 MHz reference clock and a host on the two-wire control bus.
//
// Contract
// - timeout fault when flash reaches programmed duration
// - bus mode: register and edge-strobe flashes time out
// - timeout fault reported in fault bit 4
// - pending timeout flag never blocks new events
// - indicator fault outside voltage window, ends inside
// - indicator fault reported in fault bit 2
// - low inductance sets fault bit 1
// - current limit ends charge phase, never disables
// - limit fixed 1.75A pin mode, selectable bus mode
// - undervoltage disables operation
// - pin mode: resume after recovery and pins low
// - bus mode: undervoltage clears output_on bit
// - undervoltage leaves other register bits unchanged
// - power-on reset: off, registers at startup values
// - any fault sets flag and stops output
// - completed fault register read clears all bits
// - bus mode: resume when fault gone and read
`ifndef FLASH_FAULT_DEFS_VH
`define FLASH_FAULT_DEFS_VH

// register addresses
`define ADDR_TIMER_SETTINGS 8'h02
`define ADDR_CONTROL_SETTINGS 8'h04
`define ADDR_FAULT_STATUS 8'h05

// control_settings fields
`define CTL_OUTPUT_MODE_LO 0
`define CTL_OUTPUT_MODE_HI 1
`define CTL_STROBE_EN 2
`define CTL_TORCH_EN 3
`define CTL_STROBE_LEVEL 4
`define CTL_CURRENT_LIMIT_SEL_LO 5
`define CTL_CURRENT_LIMIT_SEL_HI 6
`define CTL_OUTPUT_ON 7

// fault_status fields
`define FLT_TIMEOUT 4
`define FLT_INDICATOR 2
`define FLT_INDUCTOR 1

// startup values
`define RST_CONTROL_SETTINGS 8'h00
`define RST_TIMER_SETTINGS 8'h0F
`define RST_FAULT_STATUS 8'h00

// output modes
`define MODE_OFF 2'h0
`define MODE_INDICATOR 2'h1
`define MODE_ASSIST 2'h2
`define MODE_FLASH 2'h3

// fixed 1.75 A limit code in pin-control mode
`define ILIM_PIN_MODE 2'h2

// timing: timer counts 50 ms ticks; bus mode duration = base + field ticks, pin mode fixed at PIN_MODE_TICKS
`define CLK_FREQ_KHZ 100000
`define FLASH_TICK_MS 50
`define FLASH_BASE_TICKS 5'd2
`define PIN_MODE_TICKS 5'd17

`endif

// *** design/sync_2ff.v ***
// two-flop synchroniser for a group of asynchronous levels.
// assumes inputs are slow levels; no bus coherence between bits.
`timescale 1ns/100ps
`default_nettype none

module sync_2ff #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_ce,
	// levels
	input wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_sync
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else if (i_ce) begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule // sync_2ff

`default_nettype wire

// *** design/flash_timer.v ***
// flash safety timer: counts ticks of TICK_CYCLES clocks while running.
// assumes i_run drops for at least one cycle between flashes to restart.
`timescale 1ns/100ps
`default_nettype none
`include "flash_fault_defs.vh"

module flash_timer #(
	parameter TICK_CYCLES = `CLK_FREQ_KHZ * `FLASH_TICK_MS
) (
	// clock and reset
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_ce,
	// control
	input wire i_run,
	input wire [4:0] i_ticks,
	output wire o_expire
);

	reg [22:0] cyc_q;
	reg [4:0] tick_q;
	reg expire_q;
	wire tick_end;

	// compared at full width so no bits of the count are dropped silently
	localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

	assign tick_end = ({9'h000, cyc_q} == TICK_LAST);

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cyc_q <= 23'h000000;
			tick_q <= 5'h00;
			expire_q <= 1'b0;
		end else if (i_ce) begin
			expire_q <= 1'b0;
			if (!i_run) begin
				cyc_q <= 23'h000000;
				tick_q <= 5'h00;
			end else if (tick_end) begin
				cyc_q <= 23'h000000;
				tick_q <= tick_q + 5'd1;
				if (tick_q + 5'd1 == i_ticks)
					expire_q <= 1'b1;
			end else begin
				cyc_q <= cyc_q + 23'd1;
			end
		end
	end

	assign o_expire = expire_q;

endmodule // flash_timer

`default_nettype wire

// *** design/flash_fault_supervisor.v ***
// flash fault supervisor: two-wire register slave, fault flags, flash
// timeout, current limit selection, undervoltage lockout.
// assumes comparator outputs and bus pins are asynchronous levels.
`timescale 1ns/100ps
`default_nettype none
`include "flash_fault_defs.vh"

module flash_fault_supervisor #(
	parameter [6:0] DEV_ADDR = 7'h5A, // arbitrary bus address
	parameter TICK_CYCLES = `CLK_FREQ_KHZ * `FLASH_TICK_MS
) (
	// clock, reset, enable
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_ce,
	// control mode strap: high = bus control
	input wire i_bus_mode,
	// two-wire bus
	input wire i_scl,
	input wire i_sda,
	output wire o_sda_out,
	output wire o_sda_oe,
	// enable, strobe and torch pins
	input wire i_ctrl_pin_a,
	input wire i_ctrl_pin_b,
	input wire i_strobe,
	input wire i_torch,
	// analog indications
	input wire i_indicator_pin_high,
	input wire i_indicator_pin_low,
	input wire i_inductor_low,
	input wire i_undervoltage_lockout,
	input wire i_vin_recovered,
	input wire i_charge_phase,
	input wire i_current_limit_hit,
	// converter control
	output wire [1:0] o_output_mode,
	output wire [1:0] o_current_limit_sel,
	output wire o_charge_on,
	output wire o_lockout
);

	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_ADDR = 5'b00010;
	localparam [4:0] ST_REG = 5'b00100;
	localparam [4:0] ST_WR = 5'b01000;
	localparam [4:0] ST_RD = 5'b10000;

	wire [12:0] sync_out;
	wire scl_s, sda_s, bus_mode_s, pin_a_s, pin_b_s, strobe_s, torch_s;
	wire ind_hi_s, ind_lo_s, ind_low_s, uv_s, vin_ok_s, phase_s, ilim_s;

	sync_2ff #(.WIDTH(13)) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_async({i_scl, i_sda, i_bus_mode, i_ctrl_pin_a, i_ctrl_pin_b, i_strobe,
			i_torch, i_indicator_pin_high, i_indicator_pin_low, i_inductor_low,
			i_undervoltage_lockout, i_vin_recovered, i_charge_phase}),
		.o_sync(sync_out)
	);
	assign {scl_s, sda_s, bus_mode_s, pin_a_s, pin_b_s, strobe_s, torch_s,
		ind_hi_s, ind_lo_s, ind_low_s, uv_s, vin_ok_s, phase_s} = sync_out;

	// current limit is a per-cycle signal, kept out of the group for clarity
	sync_2ff #(.WIDTH(1)) u_sync_ilim (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_async(i_current_limit_hit),
		.o_sync(ilim_s)
	);

	// bus edge detection on synchronised levels
	reg scl_d_q, sda_d_q;
	wire scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_s & ~scl_d_q;
	assign scl_fall = ~scl_s & scl_d_q;
	assign bus_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
	assign bus_stop = scl_s & scl_d_q & ~sda_d_q & sda_s;

	// registers
	reg [7:0] ctrl_q;
	reg [7:0] timer_reg_q;
	reg [7:0] fault_q;

	// bus slave state
	reg [4:0] st_q;
	reg [3:0] cnt_q;
	reg [7:0] sh_q;
	reg [7:0] ptr_q;
	reg sda_oe_q;
	reg sda_out_q;
	reg nack_q;
	reg wr_stb;
	reg rd_done;
	reg [7:0] rd_data;

	always @* begin
		if (ptr_q == `ADDR_TIMER_SETTINGS)
			rd_data = timer_reg_q;
		else if (ptr_q == `ADDR_CONTROL_SETTINGS)
			rd_data = ctrl_q;
		else if (ptr_q == `ADDR_FAULT_STATUS)
			rd_data = fault_q;
		else
			rd_data = 8'h00;
	end

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
			st_q <= ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			sda_oe_q <= 1'b0;
			sda_out_q <= 1'b0;
			nack_q <= 1'b0;
			wr_stb <= 1'b0;
			rd_done <= 1'b0;
		end else if (i_ce) begin
			scl_d_q <= scl_s;
			sda_d_q <= sda_s;
			wr_stb <= 1'b0;
			rd_done <= 1'b0;
			if (bus_start) begin
				st_q <= ST_ADDR;
				cnt_q <= 4'h0;
				sda_oe_q <= 1'b0;
			end else if (bus_stop) begin
				st_q <= ST_IDLE;
				sda_oe_q <= 1'b0;
			end else if (st_q != ST_IDLE && scl_rise) begin
				if (cnt_q < 4'd8) begin
					sh_q <= {sh_q[6:0], sda_s};
					cnt_q <= cnt_q + 4'd1;
				end else begin
					nack_q <= sda_s;
					cnt_q <= 4'd9;
				end
			end else if (st_q != ST_IDLE && scl_fall) begin
				if (cnt_q == 4'd8) begin
					case (st_q)
					ST_ADDR: begin
						if (sh_q[7:1] == DEV_ADDR) begin
							sda_oe_q <= 1'b1;
							if (sh_q[0]) begin
								st_q <= ST_RD;
								sh_q <= rd_data;
							end else begin
								st_q <= ST_REG;
							end
						end else begin
							st_q <= ST_IDLE;
						end
					end
					ST_REG: begin
						ptr_q <= sh_q;
						sda_oe_q <= 1'b1;
						st_q <= ST_WR;
					end
					ST_WR: begin
						wr_stb <= 1'b1;
						sda_oe_q <= 1'b1;
					end
					default: begin
						// byte fully sent: the read counts as completed here
						rd_done <= 1'b1;
						sda_oe_q <= 1'b0;
					end
					endcase
				end else if (cnt_q == 4'd9) begin
					cnt_q <= 4'h0;
					if (st_q == ST_RD && nack_q && sda_oe_q == 1'b0) begin
						st_q <= ST_IDLE;
						sda_oe_q <= 1'b0;
					end else if (st_q == ST_RD) begin
						if (!sda_oe_q)
							sh_q <= rd_data;
						sda_oe_q <= sda_oe_q ? ~sh_q[7] : ~rd_data[7];
					end else begin
						sda_oe_q <= 1'b0;
					end
				end else if (st_q == ST_RD) begin
					sda_oe_q <= ~sh_q[7];
				end
			end
			if (wr_stb || rd_done)
				ptr_q <= ptr_q + 8'd1;
		end
	end

	assign o_sda_out = sda_out_q;
	assign o_sda_oe = sda_oe_q;

	// fault conditions and operating state
	wire ind_cond = ind_hi_s | ind_lo_s;
	wire block_cond = ind_cond | ind_low_s;
	wire pins_low = ~pin_a_s & ~pin_b_s;
	wire fault_rd = rd_done & (ptr_q == `ADDR_FAULT_STATUS);
	wire ctrl_wr = wr_stb & (ptr_q == `ADDR_CONTROL_SETTINGS);
	wire timer_wr = wr_stb & (ptr_q == `ADDR_TIMER_SETTINGS);

	reg lock_q;
	reg pin_fault_q;
	reg flash_q;
	reg strobe_d_q;
	reg pins_both_d_q;
	reg strobe_edge_run_q;
	reg [1:0] mode_q;
	reg [1:0] ilim_q;
	reg charge_q;
	reg ilim_cut_q;
	wire timer_expire;

	// a pending timeout flag is left out of the blocking set
	wire bus_blocked = fault_q[`FLT_INDICATOR] | fault_q[`FLT_INDUCTOR];
	wire enabled = ~lock_q & ~uv_s & (bus_mode_s ? ~bus_blocked : ~pin_fault_q);

	wire strobe_rise = strobe_s & ~strobe_d_q;
	wire pins_both = pin_a_s & pin_b_s;
	wire out_on = ctrl_q[`CTL_OUTPUT_ON];
	wire [1:0] om = {ctrl_q[`CTL_OUTPUT_MODE_HI], ctrl_q[`CTL_OUTPUT_MODE_LO]};
	wire reg_flash = out_on & (om == `MODE_FLASH);
	wire strobe_arm = out_on & ctrl_q[`CTL_STROBE_EN];

	// flash start and hold conditions for both control modes
	wire flash_start = enabled & ~flash_q & (bus_mode_s ?
		(reg_flash | (strobe_arm & strobe_rise)) : (pins_both & ~pins_both_d_q));
	wire flash_hold = enabled & ~timer_expire & (bus_mode_s ?
		(strobe_edge_run_q | (ctrl_q[`CTL_STROBE_LEVEL] & strobe_s & strobe_arm) |
		reg_flash) : pins_both);
	wire flash_end = flash_q & ~flash_hold;

	wire [4:0] ticks = bus_mode_s ? `FLASH_BASE_TICKS + {1'b0, timer_reg_q[3:0]} :
		`PIN_MODE_TICKS;

	flash_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_run(flash_q),
		.i_ticks(ticks),
		.o_expire(timer_expire)
	);

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_q <= `RST_CONTROL_SETTINGS;
			timer_reg_q <= `RST_TIMER_SETTINGS;
			fault_q <= `RST_FAULT_STATUS;
			lock_q <= 1'b0;
			pin_fault_q <= 1'b0;
			flash_q <= 1'b0;
			strobe_d_q <= 1'b0;
			pins_both_d_q <= 1'b0;
			strobe_edge_run_q <= 1'b0;
		end else if (i_ce) begin
			strobe_d_q <= strobe_s;
			pins_both_d_q <= pins_both;
			if (timer_wr)
				timer_reg_q <= sh_q;
			// hardware clears of output_on win over a host write
			if (ctrl_wr)
				ctrl_q <= sh_q;
			if (uv_s)
				ctrl_q[`CTL_OUTPUT_ON] <= 1'b0;
			else if (bus_mode_s && flash_end)
				ctrl_q[`CTL_OUTPUT_ON] <= 1'b0;
			// sticky flags: a new event wins over the read clear
			if (fault_rd)
				fault_q <= 8'h00;
			if (timer_expire && flash_q)
				fault_q[`FLT_TIMEOUT] <= 1'b1;
			if (ind_cond)
				fault_q[`FLT_INDICATOR] <= 1'b1;
			if (ind_low_s)
				fault_q[`FLT_INDUCTOR] <= 1'b1;
			// undervoltage lock; pin mode also waits for both pins low
			if (uv_s)
				lock_q <= 1'b1;
			else if (vin_ok_s && (bus_mode_s || pins_low))
				lock_q <= 1'b0;
			if (block_cond)
				pin_fault_q <= 1'b1;
			else if (pins_low)
				pin_fault_q <= 1'b0;
			if (flash_start) begin
				flash_q <= 1'b1;
				strobe_edge_run_q <= bus_mode_s & ~reg_flash & ~ctrl_q[`CTL_STROBE_LEVEL];
			end else if (flash_end) begin
				flash_q <= 1'b0;
				strobe_edge_run_q <= 1'b0;
			end
		end
	end

	// output mode, current limit and charge gating
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_q <= `MODE_OFF;
			ilim_q <= `ILIM_PIN_MODE;
			charge_q <= 1'b0;
			ilim_cut_q <= 1'b0;
		end else if (i_ce) begin
			if (!enabled)
				mode_q <= `MODE_OFF;
			else if (flash_q)
				mode_q <= `MODE_FLASH;
			else if (bus_mode_s && out_on && om != `MODE_FLASH)
				mode_q <= om;
			else if (bus_mode_s ? (ctrl_q[`CTL_TORCH_EN] & torch_s) : torch_s)
				mode_q <= `MODE_ASSIST;
			else if (!bus_mode_s && !pin_a_s && pin_b_s)
				mode_q <= `MODE_ASSIST;
			else if (!bus_mode_s && pin_a_s && !pin_b_s)
				mode_q <= `MODE_INDICATOR;
			else
				mode_q <= `MODE_OFF;
			// code 0..3 selects 1.25, 1.5, 1.75, 2 A
			ilim_q <= bus_mode_s ? {ctrl_q[`CTL_CURRENT_LIMIT_SEL_HI],
				ctrl_q[`CTL_CURRENT_LIMIT_SEL_LO]} : `ILIM_PIN_MODE;
			// limit only trims this charge phase; the next phase starts afresh
			if (!phase_s)
				ilim_cut_q <= 1'b0;
			else if (ilim_s)
				ilim_cut_q <= 1'b1;
			charge_q <= enabled & (mode_q != `MODE_OFF) & phase_s & ~ilim_s & ~ilim_cut_q;
		end
	end

	assign o_output_mode = mode_q;
	assign o_current_limit_sel = ilim_q;
	assign o_charge_on = charge_q;
	assign o_lockout = lock_q;

endmodule // flash_fault_supervisor

`default_nettype wire

// *** verif/flash_fault_supervisor_assertions.sv ***
// concurrent checks on the supervisor's top-level ports.
// assumes i_ce held high and a bound TICK_CYCLES equal to the design's.
`timescale 1ns/100ps
`default_nettype none

module flash_fault_supervisor_assertions #(
	parameter TICK_CYCLES = 5000000
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// observed inputs
	input wire logic i_bus_mode,
	input wire logic i_ctrl_pin_a,
	input wire logic i_ctrl_pin_b,
	input wire logic i_undervoltage_lockout,
	input wire logic i_charge_phase,
	input wire logic i_current_limit_hit,
	// observed outputs
	input wire logic [1:0] o_output_mode,
	input wire logic [1:0] o_current_limit_sel,
	input wire logic o_charge_on,
	input wire logic o_lockout
);
	// longest legal flash: 17 ticks plus synchroniser slack
	localparam int MAX_FLASH = 17 * TICK_CYCLES + 8;
	int flash_cnt;

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			flash_cnt <= 0;
		else if (o_output_mode == 2'h3)
			flash_cnt <= flash_cnt + 1;
		else
			flash_cnt <= 0;
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	AST_UV_LOCK: assert property ($rose(i_undervoltage_lockout) |-> ##[1:6] o_lockout)
		else $error("lockout not raised after undervoltage");
	AST_LOCK_OFF: assert property (o_lockout [*3] |-> o_output_mode == 2'h0 && !o_charge_on)
		else $error("output active during lockout");
	AST_UV_HOLD: assert property (o_lockout && i_undervoltage_lockout |=> o_lockout)
		else $error("lockout released while undervoltage");
	AST_PIN_HOLD: assert property (o_lockout && !i_bus_mode
		&& (i_ctrl_pin_a || i_ctrl_pin_b) |=> o_lockout)
		else $error("pin mode lockout released with a pin high");
	AST_LIMIT_CUT: assert property (i_current_limit_hit [*6] |-> !o_charge_on)
		else $error("charge kept on at current limit");
	AST_NO_PHASE: assert property (!i_charge_phase [*6] |-> !o_charge_on)
		else $error("charge on outside charge phase");
	AST_LIMIT_KEEPS: assert property ($rose(i_current_limit_hit)
		&& o_output_mode == 2'h2 |=> (o_output_mode == 2'h2) [*4])
		else $error("current limit disabled the output");
	AST_PIN_LIMIT: assert property (!i_bus_mode [*6] |-> o_current_limit_sel == 2'h2)
		else $error("pin mode limit not fixed");
	AST_FLASH_BOUND: assert property (flash_cnt <= MAX_FLASH)
		else $error("flash outlived its timeout");
endmodule // flash_fault_supervisor_assertions

`default_nettype wire

// *** verif/flash_bus_host.sv ***
// host model on the two-wire bus: register write and pointer-then-read.
// assumes an external pull-up resolves the data line; 160 ns bit period.
`timescale 1ns/100ps
`default_nettype none

module flash_bus_host #(
	parameter logic [6:0] DEV_ADDR = 7'h5A
) (
	// clock
	input wire logic i_ref_clk,
	// bus lines, high = released
	output logic o_scl,
	output logic o_sda,
	input wire logic i_sda
);
	int nacks = 0;

	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task q(input logic c, input logic d, input int n);
		o_scl <= c;
		o_sda <= d;
		repeat (n) @(posedge i_ref_clk);
	endtask

	// data moves only while scl is low, so no false start or stop
	task xbit(input logic d, output logic r);
		q(1'b0, o_sda, 4);
		q(1'b0, d, 4);
		q(1'b1, d, 8);
		r = i_sda;
	endtask

	task start;
		q(1'b0, o_sda, 4);
		q(1'b0, 1'b1, 4);
		q(1'b1, 1'b1, 8);
		q(1'b1, 1'b0, 8);
	endtask

	task stop;
		q(1'b0, o_sda, 4);
		q(1'b0, 1'b0, 4);
		q(1'b1, 1'b0, 8);
		q(1'b1, 1'b1, 8);
	endtask

	task wbyte(input logic [7:0] b);
		logic a;
		for (int i = 7; i >= 0; i--)
			xbit(b[i], a);
		xbit(1'b1, a);
		if (a !== 1'b0)
			nacks++;
	endtask

	task rbyte(output logic [7:0] b);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			xbit(1'b1, a);
			b[i] = a;
		end
		xbit(1'b1, a);
	endtask

	task wr(input logic [7:0] ptr, input logic [7:0] data);
		start();
		wbyte({DEV_ADDR, 1'b0});
		wbyte(ptr);
		wbyte(data);
		stop();
	endtask

	// the fault register read clears its flags once the data byte is sent, before the stop
	task rd(input logic [7:0] ptr, output logic [7:0] data);
		start();
		wbyte({DEV_ADDR, 1'b0});
		wbyte(ptr);
		start();
		wbyte({DEV_ADDR, 1'b1});
		rbyte(data);
		stop();
	endtask
endmodule // flash_bus_host

`default_nettype wire

// *** verif/flash_fault_supervisor_bench.sv ***
// self-checking bench: host model on the bus, analog flags driven directly.
// assumes TICK_CYCLES of 20 so one timer tick is 20 clocks.
`timescale 1ns/100ps
`default_nettype none

module flash_fault_supervisor_bench;
	localparam int TICK = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic bus_mode = 1'b1;
	logic pin_a = 1'b0;
	logic pin_b = 1'b0;
	logic strobe = 1'b0;
	logic torch = 1'b0;
	logic ind_hi = 1'b0;
	logic ind_lo = 1'b0;
	logic coil_low = 1'b0;
	logic uv = 1'b0;
	logic vin_ok = 1'b1;
	logic phase = 1'b0;
	logic lim_hit = 1'b0;
	logic [7:0] rd;
	int run_len = 0;
	int last_len = 0;
	int fails = 0;
	int checks_done = 0;
	wire logic scl;
	wire logic host_sda;
	wire logic sda_out;
	wire logic sda_oe;
	wire logic [1:0] mode;
	wire logic [1:0] lim_sel;
	wire logic charge;
	wire logic lock;
	wire logic sda_line = host_sda & (sda_oe ? sda_out : 1'b1);
	wire logic [2:0] obs = {lock, mode};

	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (mode === 2'h3) begin
			run_len <= run_len + 1;
		end else begin
			if (run_len != 0)
				last_len <= run_len;
			run_len <= 0;
		end
	end

	flash_fault_supervisor #(.DEV_ADDR(7'h5A), .TICK_CYCLES(TICK)) DUT (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_bus_mode(bus_mode),
		.i_scl(scl), .i_sda(sda_line), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.i_ctrl_pin_a(pin_a), .i_ctrl_pin_b(pin_b), .i_strobe(strobe), .i_torch(torch),
		.i_indicator_pin_high(ind_hi), .i_indicator_pin_low(ind_lo),
		.i_inductor_low(coil_low), .i_undervoltage_lockout(uv), .i_vin_recovered(vin_ok),
		.i_charge_phase(phase), .i_current_limit_hit(lim_hit), .o_output_mode(mode),
		.o_current_limit_sel(lim_sel), .o_charge_on(charge), .o_lockout(lock));

	flash_bus_host #(.DEV_ADDR(7'h5A)) host (.i_ref_clk(clk), .o_scl(scl), .o_sda(host_sda),
		.i_sda(sda_line));

	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task wait_obs(input string nm, input logic [2:0] exp, input int lim);
		int n;
		n = 0;
		while (obs !== exp && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(nm, {5'h00, obs}, {5'h00, exp});
	endtask

	task rdchk(input string nm, input logic [7:0] ptr, input logic [7:0] exp);
		host.rd(ptr, rd);
		chk(nm, rd, exp);
	endtask

	// flash length is taken from the free-running monitor, since the bus
	// write that starts a flash may still be finishing when it begins
	task flash(input string nm, input int ticks);
		repeat (8) @(posedge clk);
		while (mode === 2'h3 && run_len < 2000)
			@(posedge clk);
		@(posedge clk);
		chk(nm, {7'h00, last_len >= ticks * TICK && last_len <= ticks * TICK + 8}, 8'h01);
		// every flash in these tests ends with the output off
		wait_obs(nm, 3'b000, 4);
		last_len <= 0;
	endtask

	task summarize;
		if (fails == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		summarize();
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		rdchk("control", 8'h04, 8'h00);
		rdchk("fault", 8'h05, 8'h00);
		rdchk("timer", 8'h02, 8'h0F);
		host.wr(8'h07, 8'h5A);
		rdchk("unmapped", 8'h07, 8'h00);
		for (int c = 0; c < 4; c++) begin
			host.wr(8'h04, {1'b0, c[1:0], 5'h00});
			repeat (4) @(posedge clk);
			chk("limit_sel", {6'h00, lim_sel}, {6'h00, c[1:0]});
		end
		host.wr(8'h02, 8'h00);
		host.wr(8'h04, 8'h83);
		flash("reg flash", 2);
		rdchk("control", 8'h04, 8'h03);
		host.wr(8'h04, 8'h84);
		strobe <= 1'b1;
		repeat (4) @(posedge clk);
		strobe <= 1'b0;
		flash("strobe flash", 2);
		rdchk("fault", 8'h05, 8'h10);
		rdchk("fault", 8'h05, 8'h00);
		ind_hi <= 1'b1;
		repeat (8) @(posedge clk);
		ind_hi <= 1'b0;
		repeat (8) @(posedge clk);
		rdchk("fault", 8'h05, 8'h04);
		ind_lo <= 1'b1;
		coil_low <= 1'b1;
		repeat (8) @(posedge clk);
		ind_lo <= 1'b0;
		coil_low <= 1'b0;
		host.wr(8'h04, 8'h83);
		chk("blocked mode", {6'h00, mode}, 8'h00);
		host.wr(8'h04, 8'h00);
		rdchk("fault", 8'h05, 8'h06);
		host.wr(8'h04, 8'h83);
		flash("after read", 2);
		host.wr(8'h04, 8'h81);
		wait_obs("indicator", 3'b001, 20);
		host.wr(8'h04, 8'h08);
		torch <= 1'b1;
		wait_obs("torch", 3'b010, 20);
		torch <= 1'b0;
		wait_obs("torch off", 3'b000, 20);
		host.wr(8'h04, 8'hC2);
		phase <= 1'b1;
		wait_obs("assist", 3'b010, 20);
		repeat (6) @(posedge clk);
		chk("charge", {7'h00, charge}, 8'h01);
		lim_hit <= 1'b1;
		repeat (6) @(posedge clk);
		chk("charge", {7'h00, charge}, 8'h00);
		wait_obs("assist kept", 3'b010, 0);
		lim_hit <= 1'b0;
		repeat (6) @(posedge clk);
		chk("charge cut", {7'h00, charge}, 8'h00);
		phase <= 1'b0;
		repeat (4) @(posedge clk);
		phase <= 1'b1;
		repeat (6) @(posedge clk);
		chk("charge again", {7'h00, charge}, 8'h01);
		phase <= 1'b0;
		uv <= 1'b1;
		vin_ok <= 1'b0;
		wait_obs("undervoltage_lockout", 3'b100, 20);
		rdchk("control", 8'h04, 8'h42);
		uv <= 1'b0;
		vin_ok <= 1'b1;
		wait_obs("recover", 3'b000, 20);
		bus_mode <= 1'b0;
		pin_a <= 1'b1;
		pin_b <= 1'b1;
		flash("pin flash", 17);
		chk("pin limit", {6'h00, lim_sel}, 8'h02);
		pin_b <= 1'b0;
		wait_obs("pin indicator", 3'b001, 20);
		pin_a <= 1'b0;
		pin_b <= 1'b1;
		wait_obs("pin assist", 3'b010, 20);
		uv <= 1'b1;
		vin_ok <= 1'b0;
		wait_obs("pin undervoltage_lockout", 3'b100, 20);
		uv <= 1'b0;
		vin_ok <= 1'b1;
		repeat (10) @(posedge clk);
		wait_obs("pin held", 3'b100, 0);
		pin_b <= 1'b0;
		wait_obs("pin resume", 3'b000, 20);
		chk("bus nacks", host.nacks[7:0], 8'h00);
		summarize();
	end
endmodule // flash_fault_supervisor_bench

bind flash_fault_supervisor flash_fault_supervisor_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
	.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_bus_mode(i_bus_mode),
	.i_ctrl_pin_a(i_ctrl_pin_a), .i_ctrl_pin_b(i_ctrl_pin_b),
	.i_undervoltage_lockout(i_undervoltage_lockout), .i_charge_phase(i_charge_phase),
	.i_current_limit_hit(i_current_limit_hit), .o_output_mode(o_output_mode),
	.o_current_limit_sel(o_current_limit_sel), .o_charge_on(o_charge_on),
	.o_lockout(o_lockout));

`default_nettype wire
